// ### logic/hhpwm_defines.vh
`ifndef HHPWM_DEFINES_VH
`define HHPWM_DEFINES_VH
// register byte addresses
`define HHPWM_ADDR_CTRL 12'h084
`define HHPWM_ADDR_DUTY 12'h088
`define HHPWM_ADDR_MISC 12'h0D8
`define HHPWM_ADDR_STAT 12'h0DC
// control register fields
`define HHPWM_MODE_LSB 0
`define HHPWM_FREQ_LSB 3
`define HHPWM_SRC_LSB 5
`define HHPWM_VSEL_BIT 7
// misc register fields
`define HHPWM_PWMIN_SEL_BIT 1
`define HHPWM_GRP_ENG_BIT 2
// reset values
`define HHPWM_CTRL_RST 8'h00
`define HHPWM_DUTY_RST 8'h00
`define HHPWM_MISC_RST 8'h02
// duty sources
`define HHPWM_SRC_REG 2'h0
`define HHPWM_SRC_ENG 2'h1
`define HHPWM_SRC_GRP 2'h2
// base frequencies in Hz, times ten
`define HHPWM_F0_DHZ 1570
`define HHPWM_F1_DHZ 4900
`define HHPWM_F2_DHZ 9800
`define HHPWM_F3_DHZ 39000
`define HHPWM_CLK_HZ 200000000
// power-save wait, seconds
`define HHPWM_PS_WAIT_S 1
`endif

// ### logic/hhpwm_top.v
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "hhpwm_defines.vh"
module hhpwm_top #(
   parameter CLK_HZ = `HHPWM_CLK_HZ,
   parameter PS_WAIT_CYC = `HHPWM_PS_WAIT_S * `HHPWM_CLK_HZ
) (
   // clock and reset
   input wire i_ref_clk,
   input wire i_resetn,
   // apb slave
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata,
   output reg [31:0] o_prdata,
   output reg o_pready,
   output reg o_pslverr,
   // duty sources
   input wire [7:0] i_eng_duty,
   input wire [7:0] i_grp_duty,
   // power management
   input wire i_idle_req,
   output reg o_pwr_save,
   output reg o_boost_cv,
   output reg o_boost_5v0,
   // h-bridge gates
   output reg o_motor_channel_a_pin,
   output reg o_motor_channel_b_pin,
   output reg o_a_high_on,
   output reg o_a_low_on,
   output reg o_b_high_on,
   output reg o_b_low_on,
   output reg o_haptic_active
);
   localparam [1:0] ST_IDLE = 2'h1;
   localparam [1:0] ST_RUN = 2'h2;
   localparam [31:0] DIV0 = CLK_HZ * 10 / (`HHPWM_F0_DHZ * 256);
   localparam [31:0] DIV1 = CLK_HZ * 10 / (`HHPWM_F1_DHZ * 256);
   localparam [31:0] DIV2 = CLK_HZ * 10 / (`HHPWM_F2_DHZ * 256);
   localparam [31:0] DIV3 = CLK_HZ * 10 / (`HHPWM_F3_DHZ * 256);
   localparam [31:0] PS_CYC = PS_WAIT_CYC;

   reg [7:0] ctrl_r;
   reg [7:0] duty_reg_r;
   reg [7:0] misc_r;
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [31:0] pre_r;
   reg [7:0] cnt_r;
   reg [7:0] duty_act_r;
   reg [2:0] mode_act_r;
   reg [1:0] freq_act_r;
   reg [31:0] wait_r;
   reg [7:0] duty_src;
   reg [31:0] div_sel;
   reg pwm_a;
   reg en_a;
   reg en_b;
   reg [31:0] rd_data;
   reg addr_ok;
   wire [2:0] motor_drive_mode_field;
   wire haptic_sel;
   wire tick;
   wire wr_fire;

   assign motor_drive_mode_field = ctrl_r[`HHPWM_MODE_LSB +: 3];
   // haptic enabled, pin mux chosen and engines not owning group pwm
   assign haptic_sel = ~misc_r[`HHPWM_PWMIN_SEL_BIT] & ~misc_r[`HHPWM_GRP_ENG_BIT] &
      (motor_drive_mode_field[1:0] != 2'h0);
   assign wr_fire = i_psel & i_penable & i_pwrite & o_pready;

   // apb decode
   always @* begin
      addr_ok = 1'b1;
      rd_data = 32'h00000000;
      case (i_paddr)
         `HHPWM_ADDR_CTRL: rd_data[7:0] = ctrl_r;
         `HHPWM_ADDR_DUTY: rd_data[7:0] = duty_reg_r;
         `HHPWM_ADDR_MISC: rd_data[7:0] = misc_r;
         `HHPWM_ADDR_STAT: rd_data[4:0] = {o_pwr_save, o_haptic_active, mode_act_r};
         default: addr_ok = 1'b0;
      endcase
   end

   // one wait state: ready in second access cycle
   always @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         o_pready <= 1'b0;
         o_prdata <= 32'h00000000;
         o_pslverr <= 1'b0;
         ctrl_r <= `HHPWM_CTRL_RST;
         duty_reg_r <= `HHPWM_DUTY_RST;
         misc_r <= `HHPWM_MISC_RST;
      end else begin
         o_pready <= i_psel & i_penable & ~o_pready;
         o_pslverr <= i_psel & i_penable & ~o_pready & ~addr_ok;
         o_prdata <= (i_psel & i_penable & ~o_pready & ~i_pwrite) ? rd_data : 32'h00000000;
         if (wr_fire) begin
            // only host writes reach the mode field
            if (i_paddr == `HHPWM_ADDR_CTRL) ctrl_r <= i_pwdata[7:0];
            if (i_paddr == `HHPWM_ADDR_DUTY) duty_reg_r <= i_pwdata[7:0];
            if (i_paddr == `HHPWM_ADDR_MISC) misc_r <= i_pwdata[7:0];
         end
      end
   end

   // duty source mux
   always @* begin
      case (ctrl_r[`HHPWM_SRC_LSB +: 2])
         `HHPWM_SRC_ENG: duty_src = i_eng_duty;
         `HHPWM_SRC_GRP: duty_src = i_grp_duty;
         default: duty_src = duty_reg_r;
      endcase
   end

   // prescaler per base frequency; dual modes run at double rate
   always @* begin
      case (freq_act_r)
         2'h0: div_sel = DIV0;
         2'h1: div_sel = DIV1;
         2'h2: div_sel = DIV2;
         default: div_sel = DIV3;
      endcase
      if (mode_act_r[1:0] == 2'h1) div_sel = div_sel >> 1;
   end
   assign tick = (pre_r >= div_sel - 32'h00000001);

   // counter and period-start latching
   always @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         pre_r <= 32'h00000000;
         cnt_r <= 8'h00;
         duty_act_r <= 8'h00;
         mode_act_r <= 3'h0;
         freq_act_r <= 2'h0;
      end else begin
         pre_r <= tick ? 32'h00000000 : pre_r + 32'h00000001;
         if (tick) begin
            cnt_r <= cnt_r + 8'h01;
            if (cnt_r == 8'hFF) begin
               duty_act_r <= duty_src;
               mode_act_r <= haptic_sel ? motor_drive_mode_field : 3'h0;
               freq_act_r <= ctrl_r[`HHPWM_FREQ_LSB +: 2];
            end
         end
      end
   end

   // channel pattern; FFH means fully on
   always @* begin
      pwm_a = (duty_act_r == 8'hFF) | (cnt_r < duty_act_r);
      en_a = 1'b0;
      en_b = 1'b0;
      case (mode_act_r)
         3'h1: begin
            // complementary: 00H gives B on, 80H equal halves
            en_a = pwm_a;
            en_b = ~pwm_a;
         end
         3'h5: begin
            en_a = (duty_act_r != 8'h80) & pwm_a;
            en_b = (duty_act_r != 8'h80) & ~pwm_a;
         end
         3'h2: begin
            en_a = pwm_a;
            en_b = 1'b0;
         end
         3'h3: begin
            en_a = 1'b0;
            en_b = pwm_a;
         end
         3'h6: begin
            en_a = pwm_a;
            en_b = 1'b1;
         end
         3'h7: begin
            en_a = 1'b1;
            en_b = pwm_a;
         end
         default: begin
            en_a = 1'b0;
            en_b = 1'b0;
         end
      endcase
   end

   // power-save sequencing
   always @* begin
      case (state_r)
         ST_IDLE: state_nxt = (mode_act_r[1:0] != 2'h0) ? ST_RUN : ST_IDLE;
         ST_RUN: state_nxt = (mode_act_r[1:0] == 2'h0 && i_idle_req && wait_r >= PS_CYC - 32'h00000001)
            ? ST_IDLE : ST_RUN;
         default: state_nxt = ST_IDLE;
      endcase
   end

   always @(posedge i_ref_clk) begin
      if (!i_resetn) begin
         state_r <= ST_IDLE;
         wait_r <= 32'h00000000;
         o_pwr_save <= 1'b0;
         o_boost_cv <= 1'b0;
         o_boost_5v0 <= 1'b0;
         o_motor_channel_a_pin <= 1'b0;
         o_motor_channel_b_pin <= 1'b0;
         o_a_high_on <= 1'b0;
         o_a_low_on <= 1'b0;
         o_b_high_on <= 1'b0;
         o_b_low_on <= 1'b0;
         o_haptic_active <= 1'b0;
      end else begin
         state_r <= state_nxt;
         // one-second rest before power-save
         if (state_r == ST_RUN && mode_act_r[1:0] == 2'h0) begin
            if (wait_r < PS_CYC) wait_r <= wait_r + 32'h00000001;
         end else begin
            wait_r <= 32'h00000000;
         end
         o_pwr_save <= (state_nxt == ST_IDLE) & i_idle_req;
         // o_boost_cv follows the applied mode, so it drops with the drive; o_boost_5v0 follows the control register
         o_boost_cv <= (mode_act_r[1:0] != 2'h0);
         o_boost_5v0 <= ctrl_r[`HHPWM_VSEL_BIT];
         o_haptic_active <= (mode_act_r[1:0] != 2'h0);
         o_motor_channel_a_pin <= en_a;
         o_motor_channel_b_pin <= en_b;
         // off channel closes its low switch in an active mode; both switches open only when no mode is applied
         o_a_high_on <= en_a;
         o_a_low_on <= ~en_a & (mode_act_r[1:0] != 2'h0);
         o_b_high_on <= en_b;
         o_b_low_on <= ~en_b & (mode_act_r[1:0] != 2'h0);
      end
   end
endmodule
`default_nettype wire

// ### tb/hhpwm_motor_model.sv
`timescale 1ns/10ps
`default_nettype none
module hhpwm_motor_model (
   // clock and window clear
   input wire logic i_clk,
   input wire logic i_clr,
   // bridge legs, high = leg on
   input wire logic i_a,
   input wire logic i_b,
   // on-time and start counts per window
   output logic [15:0] o_a_on,
   output logic [15:0] o_b_on,
   output logic [15:0] o_a_rise
);
   logic a_q;
   always @(posedge i_clk) begin
      a_q <= i_a;
      if (i_clr) begin
         o_a_on <= 16'h0;
         o_b_on <= 16'h0;
         o_a_rise <= 16'h0;
      end else begin
         o_a_on <= o_a_on + 16'(i_a);
         o_b_on <= o_b_on + 16'(i_b);
         o_a_rise <= o_a_rise + 16'(i_a & !a_q);
      end
   end
endmodule
`default_nettype wire

// ### tb/hhpwm_top_sva.sv
`timescale 1ns/10ps
`default_nettype none
module hhpwm_top_sva #(parameter PS_WAIT_CYC = 50) (
   // clock, reset, bus, power
   input wire logic i_ref_clk, i_resetn, i_psel, i_penable, i_idle_req,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready, o_pslverr, o_pwr_save, o_boost_cv, o_haptic_active,
   // bridge
   input wire logic o_motor_channel_a_pin, o_motor_channel_b_pin,
   input wire logic o_a_high_on, o_a_low_on, o_b_high_on, o_b_low_on
);
   logic [31:0] idle_cnt;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);
   always @(posedge i_ref_clk)
      if (!i_resetn || o_haptic_active)
         idle_cnt <= 32'h0;
      else
         idle_cnt <= idle_cnt + 32'h1;
   sequence s_access;
      i_psel && i_penable && !o_pready;
   endsequence
   a_apb_answer: assert property (s_access |=> o_pready) else $error("no answer to access");
   a_ready_pulse: assert property (o_pready |=> !o_pready) else $error("ready held");
   a_err_ready: assert property (o_pslverr |-> o_pready) else $error("error without ready");
   a_rdata_quiet: assert property (!o_pready |-> o_prdata == 32'h0) else $error("read data outside answer");
   a_no_shoot: assert property (!(o_a_high_on && o_a_low_on) && !(o_b_high_on && o_b_low_on))
      else $error("both switches on");
   a_gate_pair: assert property (((o_a_high_on || o_a_low_on) |-> o_a_high_on == o_motor_channel_a_pin) and
      ((o_b_high_on || o_b_low_on) |-> o_b_high_on == o_motor_channel_b_pin)) else $error("gate off its channel");
   a_off_quiet: assert property (!o_haptic_active |-> !o_motor_channel_a_pin && !o_motor_channel_b_pin)
      else $error("channel active while disabled");
   a_boost_run: assert property (o_boost_cv |-> o_haptic_active || $past(o_haptic_active))
      else $error("boost request while idle");
   a_ps_wait: assert property ($rose(o_pwr_save) |-> idle_cnt >= PS_WAIT_CYC - 1)
      else $error("power save too early");
   a_ps_idle: assert property (o_pwr_save |-> $past(i_idle_req) && !o_haptic_active)
      else $error("power save without request");
endmodule
bind hhpwm_top hhpwm_top_sva #(.PS_WAIT_CYC(PS_WAIT_CYC)) u_sva (.*);
`default_nettype wire

// ### tb/haptic_hbridge_pwm_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "hhpwm_defines.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin errors++; $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module haptic_hbridge_pwm_test;
   localparam int CLK = 1996800;
   logic i_ref_clk = 0, i_resetn = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, i_idle_req = 0, clr = 0;
   logic [11:0] i_paddr = 12'h000;
   logic [31:0] i_pwdata = 32'h0, o_prdata;
   logic [7:0] i_eng_duty = 8'h00, i_grp_duty = 8'h00;
   logic o_pready, o_pslverr, o_pwr_save, o_boost_cv, o_boost_5v0, a_pin, b_pin;
   logic [15:0] a_on, b_on, a_rise;
   logic [63:0] expq[$];
   logic [7:0] dv[4] = '{8'h00, 8'h80, 8'hFF, 8'h40};
   int errors = 0, n_tests = 0, cyc = 0, prev_p = 12544;
   event win_ev;
   hhpwm_top #(.CLK_HZ(CLK), .PS_WAIT_CYC(50)) dut (.*, .o_motor_channel_a_pin(a_pin), .o_motor_channel_b_pin(b_pin),
      .o_a_high_on(), .o_a_low_on(), .o_b_high_on(), .o_b_low_on(), .o_haptic_active());
   hhpwm_motor_model motor (.i_clk(i_ref_clk), .i_clr(clr), .i_a(a_pin), .i_b(b_pin), .o_a_on(a_on), .o_b_on(b_on),
      .o_a_rise(a_rise));
   always #2.5 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc == 100000) begin
         errors++;
         results;
      end
   end
   always @(posedge i_ref_clk)
      if (o_pready && !i_pwrite)
         `CHK({31'h0, o_pslverr, o_prdata}, expq.pop_front())
   always @(win_ev)
      `CHK({13'h0, o_boost_cv, o_boost_5v0, o_pwr_save, a_rise, a_on, b_on}, expq.pop_front())
   task results;
      $display("errors %0d comparisons %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_ref_clk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_ref_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 50);
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      @(posedge i_ref_clk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      expq.push_back({31'h0, e});
      apb(1'b0, a, 32'h0);
   endtask
   function automatic int per(input logic [1:0] f, input logic dual);
      int dhz = f == 2'h0 ? `HHPWM_F0_DHZ : f == 2'h1 ? `HHPWM_F1_DHZ : f == 2'h2 ? `HHPWM_F2_DHZ : `HHPWM_F3_DHZ;
      return 256 * ((CLK * 10 / (dhz * 256)) >> dual);
   endfunction
   task automatic run(input logic [2:0] misc, input logic [7:0] ctrl, input logic [7:0] duty);
      logic [2:0] m = ctrl[2:0];
      logic dual = ctrl[1:0] == 2'h1;
      logic [7:0] d = ctrl[6:5] == 2'h1 ? i_eng_duty : ctrl[6:5] == 2'h2 ? i_grp_duty : duty;
      int p = per(ctrl[4:3], dual);
      int e = d == 8'hFF ? p : d * p / 256;
      logic act = ctrl[1:0] != 2'h0 && misc == 3'h0;
      logic off = !act || (dual && m[2] && d == 8'h80);
      int a = off ? 0 : m == 3'h3 ? 0 : m == 3'h7 ? p : e;
      int b = off ? 0 : dual ? p - e : m == 3'h2 ? 0 : m == 3'h6 ? p : e;
      apb(1'b1, `HHPWM_ADDR_MISC, {29'h0, misc});
      apb(1'b1, `HHPWM_ADDR_DUTY, {24'h0, duty});
      apb(1'b1, `HHPWM_ADDR_CTRL, {24'h0, ctrl});
      rd(`HHPWM_ADDR_CTRL, {25'h0, ctrl});
      repeat (prev_p + 4) @(posedge i_ref_clk);
      prev_p = p;
      clr <= 1'b1;
      @(posedge i_ref_clk);
      clr <= 1'b0;
      expq.push_back({13'h0, act, ctrl[7], i_idle_req, 16'(a != 0 && a != p), 16'(a), 16'(b)});
      repeat (p + 1) @(posedge i_ref_clk);
      -> win_ev;
   endtask
   initial begin
      void'($urandom(65498));
      repeat (8) @(posedge i_ref_clk);
      i_resetn <= 1'b1;
      @(posedge i_ref_clk);
      i_eng_duty <= 8'($urandom);
      i_grp_duty <= 8'($urandom);
      rd(`HHPWM_ADDR_MISC, {25'h0, `HHPWM_MISC_RST});
      rd(12'h0FC, {1'b1, 32'h0});
      for (int m = 0; m < 8; m++)
         run(3'h0, {1'($urandom), 4'h3, 3'(m)}, 8'($urandom));
      foreach (dv[i])
         run(3'h0, 8'h19, dv[i]);
      run(3'h0, 8'h1D, 8'h80);
      run(3'h0, 8'h3A, 8'h00);
      run(3'h0, 8'h5A, 8'h00);
      run(3'h2, 8'h9A, 8'h40);
      run(3'h4, 8'h1A, 8'h40);
      for (int f = 2; f >= 0; f--)
         run(3'h0, {3'h0, 2'(f), 3'h2}, 8'h80);
      i_idle_req <= 1'b1;
      run(3'h0, 8'h18, 8'h10);
      results;
   end
endmodule
`default_nettype wire
